/* common/flo_pkg.sv */
package flo_pkg;

    // Clock rate, kept in kHz so that cycle counts stay inside 32 bits
    localparam int CLK_KHZ           = 100_000;
    // Alarm output follows the fault alarm event after this nominal delay
    localparam int ALARM_DELAY_MS    = 300;
    // Relay start-up delay in normally-closed mode, kept under 2 s
    localparam int STARTUP_DELAY_MS  = 1000;
    localparam int ALARM_DELAY_CYC   = ALARM_DELAY_MS * CLK_KHZ;
    localparam int STARTUP_DELAY_CYC = STARTUP_DELAY_MS * CLK_KHZ;

    // Byte offsets of the register words
    localparam logic [7:0] ADR_FUNC_SEL   = 8'h00;
    localparam logic [7:0] ADR_RELAY_CFG  = 8'h04;
    localparam logic [7:0] ADR_SOURCE_SEL = 8'h08;
    localparam logic [7:0] ADR_START_ADJ  = 8'h0C;
    localparam logic [7:0] ADR_CUR_LOSS   = 8'h10;
    localparam logic [7:0] ADR_STATUS     = 8'h14;
    localparam logic [7:0] ADR_IRQ_STATUS = 8'h18;
    localparam logic [7:0] ADR_IRQ_MASK   = 8'h1C;

    // Field positions of the function select word
    localparam int FS_RELAY_LSB = 0;
    localparam int FS_OC0_LSB   = 8;
    localparam int FS_OC1_LSB   = 16;

    // Status word bits
    localparam int ST_ALARM = 0;
    localparam int ST_LOSS  = 1;
    localparam int ST_RELAY = 2;
    localparam int ST_READY = 3;
    localparam int ST_RAMP  = 4;

    // Interrupt status and mask bits
    localparam int IRQ_ALARM_SET = 0;
    localparam int IRQ_ALARM_CLR = 1;
    localparam int IRQ_LOSS_SET  = 2;
    localparam int IRQ_LOSS_CLR  = 3;

    // Output function codes and encodings
    localparam logic [7:0] FN_NONE    = 8'h00;
    localparam logic [7:0] FN_ALARM   = 8'h05;
    localparam logic [7:0] FN_LOSS    = 8'h06;
    localparam logic       POL_NC     = 1'h1;
    localparam logic [1:0] SRC_ANALOG = 2'h1;

    // Reset values
    localparam logic [7:0]  RST_RELAY_FN  = FN_ALARM;
    localparam logic [7:0]  RST_OC_FN     = FN_NONE;
    localparam logic        RST_POLARITY  = POL_NC;
    localparam logic [1:0]  RST_SOURCE    = SRC_ANALOG;
    localparam logic [15:0] RST_START_ADJ = 16'h0100;
    localparam logic [15:0] RST_CUR_LOSS  = 16'h3333;

    // Relay start-up sequence
    typedef enum logic [1:0] {
        FLO_ST_WAIT = 2'h0,
        FLO_ST_RUN  = 2'h1
    } flo_start_t;

    // Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } flo_wb_req_t;

    // Wishbone answer to the master
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } flo_wb_rsp_t;

    // Level that an output shows for a given function code
    function automatic logic flo_select(input logic [7:0] code,
                                        input logic alarm,
                                        input logic loss);
        logic on;
        on = 1'h0;
        if (code == FN_ALARM) begin
            on = alarm;
        end else if (code == FN_LOSS) begin
            on = loss;
        end
        return on;
    endfunction : flo_select

    // Merge write data into a word by byte enables
    function automatic logic [31:0] flo_wmask(input logic [31:0] old,
                                              input logic [31:0] wdat,
                                              input logic [3:0]  sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = wdat[b*8 +: 8];
            end
        end
        return res;
    endfunction : flo_wmask

endpackage : flo_pkg

/* hw/flo_delay.sv */
module flo_delay #(
    parameter int CYCLES = flo_pkg::ALARM_DELAY_CYC
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Level in, delayed level out
    input  wire logic d_i,
    output logic      q_o
);

    // Last count before the output takes the new level
    localparam logic [31:0] LAST = 32'(CYCLES - 1);

    typedef struct packed {
        logic        q;    // Delayed level
        logic [31:0] cnt;  // Cycles the input has differed
    } flo_dly_t;

    flo_dly_t s;
    flo_dly_t next_s;

    // A pulse shorter than the delay never reaches the output; this
    // filters chatter at the price of losing very short faults
    always_comb begin
        next_s = s;
        if (rst_i) begin
            next_s = '0;
        end else if (d_i == s.q) begin
            next_s.cnt = 32'h0;
        end else if (s.cnt >= LAST) begin
            next_s.q   = d_i;
            next_s.cnt = 32'h0;
        end else begin
            next_s.cnt = s.cnt + 32'h1;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        s <= next_s;
    end

    assign q_o = s.q;

    default clocking dcb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_DLY_FOLLOW: assert property (
        $changed(q_o) |-> (q_o == $past(d_i)) && ($past(s.cnt) == LAST))
        else $error("Delayed level changed before its delay ran out");

    AST_DLY_HOLD: assert property (
        (d_i == q_o) |=> $stable(q_o))
        else $error("Delayed level moved while input agreed with it");

endmodule : flo_delay

/* hw/flo_refloss.sv */
module flo_refloss #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Analog references and thresholds
    input  wire logic [W-1:0] volt_i,
    input  wire logic [W-1:0] curr_i,
    input  wire logic [W-1:0] start_adj_i,
    input  wire logic [W-1:0] cur_thr_i,
    // Loss flag
    output logic              loss_o
);

    typedef struct packed {
        logic loss;  // Registered loss flag
    } flo_loss_t;

    flo_loss_t s;
    flo_loss_t next_s;

    // Evaluated every cycle whatever the drive mode; no latch, so the
    // flag drops by itself once both inputs are back above threshold
    always_comb begin
        next_s = s;
        if (rst_i) begin
            next_s = '0;
        end else begin
            next_s.loss = (volt_i < start_adj_i)
                        | (curr_i < cur_thr_i);
        end
    end

    // State register, one update per clock
    always_ff @(posedge clk_i) begin
        s <= next_s;
    end

    assign loss_o = s.loss;

    default clocking dcb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_LOSS_VOLT: assert property (
        (volt_i < start_adj_i) |=> loss_o)
        else $error("Low voltage reference not flagged");

    AST_LOSS_CURR: assert property (
        (curr_i < cur_thr_i) |=> loss_o)
        else $error("Low current reference not flagged");

    AST_LOSS_SELF_CLEAR: assert property (
        (volt_i >= start_adj_i && curr_i >= cur_thr_i) |=> !loss_o)
        else $error("Loss flag did not clear by itself");

endmodule : flo_refloss

/* hw/flo_top.sv */
// Contract
// - Alarm flag follows fault while in trip mode
// - Code 05 puts alarm on relay or OC
// - Relay polarity resets to normally closed
// - NC relay energizes after start-up delay
// - Alarm output follows event after 300 ms
// - NC polarity: trip de-energizes the relay
// - NO polarity: energize only during trip
// - Code 06: flag when voltage below start
// - Flag when current below loss threshold
// - Loss never trips; flag clears itself
// - Loss detection active in stop and run
// - Reference loss ramps the motor to stop; code ramps only with analog source selected
// - Start adjust is minimum nonzero frequency
//
// Implementation choices: the register offsets and the Wishbone slave port.
module flo_top #(
    parameter int ALARM_DELAY_CYC   = flo_pkg::ALARM_DELAY_CYC,
    parameter int STARTUP_DELAY_CYC = flo_pkg::STARTUP_DELAY_CYC
) (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // Register bus
    input  wire flo_pkg::flo_wb_req_t wb_i,
    output flo_pkg::flo_wb_rsp_t     wb_o,
    // Drive controller state
    input  wire logic                fault_active_i,
    input  wire logic                trip_mode_i,
    // Analog speed references
    input  wire logic [15:0]         voltage_ref_i,
    input  wire logic [15:0]         current_reference_input_i,
    // Flags
    output logic                     fault_alarm_flag_o,
    output logic                     reference_loss_flag_o,
    // Output stages
    output logic                     relay_energize_o,
    output logic [1:0]               oc_oe_n_o,
    // Drive control
    output logic                     ramp_stop_o,
    output logic [15:0]              freq_cmd_o,
    // Interrupt
    output logic                     irq_o
);

    localparam logic [31:0] START_LAST = 32'(STARTUP_DELAY_CYC - 1);

    typedef struct packed {
        flo_pkg::flo_start_t st;        // Relay start-up phase
        logic [31:0]         cnt;       // Start-up cycle count
        logic [7:0]          relay_fn;  // relay_function_select
        logic [1:0][7:0]     oc_fn;     // Open-collector functions
        logic                nc_pol;    // relay_polarity_setting
        logic [1:0]          src;       // frequency_source_select
        logic [15:0]         start_adj; // start_frequency_adjust
        logic [15:0]         cur_thr;   // Current loss threshold
        logic [3:0]          irq_stat;  // Sticky events
        logic [3:0]          irq_mask;  // Interrupt enables
        logic                alarm_d;   // Alarm flag, last cycle
        logic                loss_d;    // Loss flag, last cycle
        logic                ack;       // Bus answer
        logic [31:0]         rdat;      // Read data
        logic                relay;     // Relay coil drive
        logic [1:0]          oc_oe_n;   // Low pulls the pin low
        logic                irq;       // Interrupt line
        logic                ramp;      // Ramp-to-stop request
        logic [15:0]         freq;      // Frequency command
    } flo_top_t;

    flo_top_t s;
    flo_top_t next_s;

    logic        alarm_raw;  // Fault seen while in trip mode
    logic        alarm;      // Delayed fault_alarm_flag
    logic        loss;       // reference_loss_flag
    logic        bus_req;    // New bus request this cycle
    logic [7:0]  bus_adr;    // Word-aligned byte address
    logic [3:0]  ev;         // Events this cycle
    logic [31:0] status;     // Live status word
    logic        fn_on;      // Relay function level

    // The flag is a plain level: clearing the fault drops it, no latch
    assign alarm_raw = fault_active_i & trip_mode_i;

    // Alarm event delay toward every output stage
    flo_delay #(
        .CYCLES (ALARM_DELAY_CYC)
    ) u_alarm_delay (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (alarm_raw),
        .q_o   (alarm)
    );

    // Analog reference loss detection
    flo_refloss #(
        .W (16)
    ) u_refloss (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .volt_i      (voltage_ref_i),
        .curr_i      (current_reference_input_i),
        .start_adj_i (s.start_adj),
        .cur_thr_i   (s.cur_thr),
        .loss_o      (loss)
    );

    assign bus_req = wb_i.cyc & wb_i.stb & ~s.ack;
    assign bus_adr = {wb_i.adr[7:2], 2'h0};

    // Edge events of both flags
    always_comb begin
        ev = 4'h0;
        ev[flo_pkg::IRQ_ALARM_SET] = alarm & ~s.alarm_d;
        ev[flo_pkg::IRQ_ALARM_CLR] = ~alarm & s.alarm_d;
        ev[flo_pkg::IRQ_LOSS_SET]  = loss & ~s.loss_d;
        ev[flo_pkg::IRQ_LOSS_CLR]  = ~loss & s.loss_d;
    end

    // Live status word
    always_comb begin
        status = 32'h0;
        status[flo_pkg::ST_ALARM] = alarm;
        status[flo_pkg::ST_LOSS]  = loss;
        status[flo_pkg::ST_RELAY] = s.relay;
        status[flo_pkg::ST_READY] = (s.st == flo_pkg::FLO_ST_RUN);
        status[flo_pkg::ST_RAMP]  = s.ramp;
    end

    assign fn_on = flo_pkg::flo_select(s.relay_fn, alarm, loss);

    // Next state of the whole block
    always_comb begin
        next_s = s;
        if (rst_i) begin
            next_s          = '0;
            next_s.st       = flo_pkg::FLO_ST_WAIT;
            next_s.relay_fn = flo_pkg::RST_RELAY_FN;
            next_s.oc_fn    = {2{flo_pkg::RST_OC_FN}};
            next_s.nc_pol   = flo_pkg::RST_POLARITY;
            next_s.src      = flo_pkg::RST_SOURCE;
            next_s.start_adj = flo_pkg::RST_START_ADJ;
            next_s.cur_thr  = flo_pkg::RST_CUR_LOSS;
            next_s.oc_oe_n  = 2'h3;
        end else begin
            next_s.alarm_d = alarm;
            next_s.loss_d  = loss;
            // Start-up timer; runs once after reset, polarity aside
            if (s.st == flo_pkg::FLO_ST_WAIT) begin
                if (s.cnt >= START_LAST) begin
                    next_s.st = flo_pkg::FLO_ST_RUN;
                end else begin
                    next_s.cnt = s.cnt + 32'h1;
                end
            end
            // Relay coil: NC holds the coil on and drops it on alarm
            if (s.nc_pol == flo_pkg::POL_NC) begin
                next_s.relay = (s.st == flo_pkg::FLO_ST_RUN)
                             & ~fn_on;
            end else begin
                next_s.relay = fn_on;
            end
            // Open-collector stages, active low
            for (int i = 0; i < 2; i++) begin
                next_s.oc_oe_n[i] = ~flo_pkg::flo_select(
                    s.oc_fn[i], alarm, loss);
            end
            // Loss asks for a ramp-down only; it never feeds the alarm
            next_s.ramp = loss & (s.src == flo_pkg::SRC_ANALOG);
            if (next_s.ramp || voltage_ref_i == 16'h0) begin
                next_s.freq = 16'h0;
            end else if (voltage_ref_i < s.start_adj) begin
                next_s.freq = s.start_adj;
            end else begin
                next_s.freq = voltage_ref_i;
            end
            // Sticky events; an event in the clearing read survives
            next_s.irq_stat = s.irq_stat | ev;
            next_s.ack      = bus_req;
            next_s.rdat     = 32'h0;
            if (bus_req && !wb_i.we) begin
                case (bus_adr)
                    flo_pkg::ADR_FUNC_SEL: begin
                        next_s.rdat = {8'h0, s.oc_fn[1], s.oc_fn[0],
                                       s.relay_fn};
                    end
                    flo_pkg::ADR_RELAY_CFG: begin
                        next_s.rdat = {31'h0, s.nc_pol};
                    end
                    flo_pkg::ADR_SOURCE_SEL: begin
                        next_s.rdat = {30'h0, s.src};
                    end
                    flo_pkg::ADR_START_ADJ: begin
                        next_s.rdat = {16'h0, s.start_adj};
                    end
                    flo_pkg::ADR_CUR_LOSS: begin
                        next_s.rdat = {16'h0, s.cur_thr};
                    end
                    flo_pkg::ADR_STATUS: begin
                        next_s.rdat = status;
                    end
                    flo_pkg::ADR_IRQ_STATUS: begin
                        next_s.rdat     = {28'h0, s.irq_stat};
                        next_s.irq_stat = ev;  // Set wins over clear
                    end
                    flo_pkg::ADR_IRQ_MASK: begin
                        next_s.rdat = {28'h0, s.irq_mask};
                    end
                    default: begin
                        next_s.rdat = 32'h0;  // Unmapped reads zero
                    end
                endcase
            end
            if (bus_req && wb_i.we) begin
                case (bus_adr)
                    flo_pkg::ADR_FUNC_SEL: begin
                        {next_s.oc_fn[1], next_s.oc_fn[0],
                         next_s.relay_fn} = 24'(flo_pkg::flo_wmask(
                            {8'h0, s.oc_fn[1], s.oc_fn[0], s.relay_fn},
                            wb_i.dat, wb_i.sel));
                    end
                    flo_pkg::ADR_RELAY_CFG: begin
                        if (wb_i.sel[0]) begin
                            next_s.nc_pol = wb_i.dat[0];
                        end
                    end
                    flo_pkg::ADR_SOURCE_SEL: begin
                        if (wb_i.sel[0]) begin
                            next_s.src = wb_i.dat[1:0];
                        end
                    end
                    flo_pkg::ADR_START_ADJ: begin
                        next_s.start_adj = 16'(flo_pkg::flo_wmask(
                            {16'h0, s.start_adj}, wb_i.dat, wb_i.sel));
                    end
                    flo_pkg::ADR_CUR_LOSS: begin
                        next_s.cur_thr = 16'(flo_pkg::flo_wmask(
                            {16'h0, s.cur_thr}, wb_i.dat, wb_i.sel));
                    end
                    flo_pkg::ADR_IRQ_MASK: begin
                        if (wb_i.sel[0]) begin
                            next_s.irq_mask = wb_i.dat[3:0];
                        end
                    end
                    default: begin
                        next_s.rdat = 32'h0;  // Read-only or unmapped
                    end
                endcase
            end
            next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
        end
    end

    // State register; every flag moves at most once per clock
    always_ff @(posedge clk_i) begin
        s <= next_s;
    end

    // Outputs, each straight from a flip-flop
    // One driver for the whole answer struct
    assign wb_o                  = {s.ack, s.rdat};
    assign fault_alarm_flag_o    = alarm;
    assign reference_loss_flag_o = loss;
    assign relay_energize_o      = s.relay;
    assign oc_oe_n_o             = s.oc_oe_n;
    assign ramp_stop_o           = s.ramp;
    assign freq_cmd_o            = s.freq;
    assign irq_o                 = s.irq;

    default clocking dcb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_POL_RESET: assert property (
        $past(rst_i) |-> (s.nc_pol == flo_pkg::POL_NC)
                         && (s.relay_fn == flo_pkg::FN_ALARM))
        else $error("Relay setup not at normally closed after reset");

    AST_NC_STARTUP: assert property (
        (s.st == flo_pkg::FLO_ST_WAIT && s.nc_pol) |=> !relay_energize_o)
        else $error("Relay energized before start-up delay ended");

    AST_NC_TRIP: assert property (
        (s.nc_pol && s.relay_fn == flo_pkg::FN_ALARM && alarm)
        |=> !relay_energize_o)
        else $error("Normally closed relay kept energized on trip");

    AST_NO_FOLLOW: assert property (
        (!s.nc_pol && s.relay_fn == flo_pkg::FN_ALARM)
        |=> (relay_energize_o == $past(fault_alarm_flag_o)))
        else $error("Normally open relay does not follow the alarm");

    AST_OC_LOSS: assert property (
        (s.oc_fn[0] == flo_pkg::FN_LOSS)
        |=> (oc_oe_n_o[0] == !$past(reference_loss_flag_o)))
        else $error("Open collector output misses the loss flag");

    AST_RAMP: assert property (
        (loss && s.src == flo_pkg::SRC_ANALOG)
        |=> ramp_stop_o && (freq_cmd_o == 16'h0))
        else $error("Reference loss did not request a ramp to stop");

    AST_MIN_FREQ: assert property (
        (freq_cmd_o != 16'h0 && $stable(s.start_adj))
        |-> (freq_cmd_o >= s.start_adj))
        else $error("Frequency command below start adjustment");

    AST_ALARM_DELAY: assert property (
        $changed(fault_alarm_flag_o)
        |-> (fault_alarm_flag_o == $past(fault_active_i & trip_mode_i)))
        else $error("Alarm flag moved against fault in trip mode");

endmodule : flo_top

/* sim/flo_alarm_load.sv */
module flo_alarm_load (
    // Coil and open-collector drives from the block
    input  wire logic       relay_energize_i,
    input  wire logic [1:0] oc_oe_n_i,
    // Alarm loop state and terminal levels
    output logic            loop_closed_o,
    output logic [1:0]      oc_pin_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Closed loop means no alarm, so a dead coil or broken wire alarms
    assign loop_closed_o = relay_energize_i;
    // Pull-up on each terminal: low only while its transistor conducts
    assign oc_pin_o = oc_oe_n_i;
endmodule : flo_alarm_load

/* sim/tb_fault_and_input_loss_outputs.sv */
module tb_fault_and_input_loss_outputs;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int AD = 4; // Shortened alarm delay
    localparam int SD = 8; // Shortened start-up delay
    logic                 clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    flo_pkg::flo_wb_req_t wb_i  = '0;
    flo_pkg::flo_wb_rsp_t wb_o;
    logic                 fault_i = 1'b0;
    logic                 trip_i  = 1'b0;
    logic [15:0]          volt_i  = 16'h1000;
    logic [15:0]          curr_i  = 16'hFFFF;
    logic                 alarm, loss, relay, ramp, irq, loop_closed;
    logic [1:0]           oc_n, oc_pin;
    logic [15:0]          freq;
    logic [31:0]          rd;
    int                   error_cnt = 0;
    int                   samples_checked = 0;
    int                   v, c, l;
    int                   adj = 16'h0100; // Start adjust after reset
    int                   thr = 16'h3333; // Current threshold after reset
    logic [7:0]           ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
                                     8'h1C, 8'h20};
    logic [31:0]          rv [7] = '{32'h05, 32'h01, 32'h01, 32'h0100,
                                     32'h3333, 32'h00, 32'h00};

    // Free-running 100 MHz clock
    always #5 clk_i = ~clk_i;

    flo_top #(.ALARM_DELAY_CYC(AD), .STARTUP_DELAY_CYC(SD)) flo_top_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
        .fault_active_i(fault_i), .trip_mode_i(trip_i),
        .voltage_ref_i(volt_i), .current_reference_input_i(curr_i),
        .fault_alarm_flag_o(alarm), .reference_loss_flag_o(loss),
        .relay_energize_o(relay), .oc_oe_n_o(oc_n),
        .ramp_stop_o(ramp), .freq_cmd_o(freq), .irq_o(irq));

    flo_alarm_load flo_alarm_load_i (.relay_energize_i(relay),
        .oc_oe_n_i(oc_n), .loop_closed_o(loop_closed), .oc_pin_o(oc_pin));

    // Counts, verdict and end of run
    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // Four-state compare against the model value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask : chk

    // One classic Wishbone cycle; waits for ack under a bound
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat);
        int n;
        wb_i <= '{cyc:1'b1, stb:1'b1, we:we, adr:adr, sel:4'hF, dat:dat};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_o.ack !== 1'b1 && n < 20);
        if (wb_o.ack !== 1'b1) begin
            error_cnt++;
            summarize();
        end
        rd = wb_o.dat;
        wb_i <= '0;
        @(posedge clk_i);
    endtask : wb

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc

    // Main sequence
    initial begin
        void'($urandom(32'h81b02744));
        cyc(8);
        rst_i <= 1'b0;
        cyc(1);
        chk(relay, 1'b0, "relay in start-up");
        for (int i = 0; i < 7; i++) begin
            wb(1'b0, ra[i], 32'h0);
            chk(rd, rv[i], "reset value");
        end
        chk(loop_closed, 1'b1, "loop after start-up");
        wb(1'b1, 8'h00, 32'h0006_0505); // OC11 alarm, OC12 loss
        // Random analog words around both thresholds, stop and run alike
        for (int i = 0; i < 24; i++) begin
            v = (i < 2) ? adj - i : $urandom_range(0, 16'h0200);
            c = (i < 2) ? thr : $urandom_range(16'h3300, 16'h3400);
            l = (v < adj) || (c < thr);
            volt_i <= 16'(v);
            curr_i <= 16'(c);
            trip_i <= i[0];
            cyc(3);
            chk(loss, l, "loss flag");
            chk(ramp, l, "ramp stop");
            chk(freq, (l || v == 0) ? 0 : (v > adj ? v : adj), "freq");
            chk(oc_pin, {~l[0], 1'b1}, "oc pins");
        end
        wb(1'b1, 8'h08, 32'h0); // Source 00: loss no longer ramps
        volt_i <= 16'(adj - 1);
        curr_i <= 16'hFFFF;
        cyc(3);
        chk(ramp, 1'b0, "no ramp off analog source");
        chk(freq, adj, "freq held at start adjust");
        volt_i <= 16'h1000;
        curr_i <= 16'hFFFF;
        trip_i <= 1'b1;
        cyc(3);
        wb(1'b0, 8'h18, 32'h0); // Drop stale sticky bits
        wb(1'b1, 8'h1C, 32'h1); // Only alarm rise unmasked
        fault_i <= 1'b1;
        cyc(2);
        fault_i <= 1'b0;
        cyc(AD + 3);
        chk(alarm, 1'b0, "short fault filtered");
        fault_i <= 1'b1;
        cyc(2);
        chk(alarm, 1'b0, "alarm before delay");
        cyc(AD + 1);
        chk(alarm, 1'b1, "alarm after delay");
        chk(loop_closed, 1'b0, "NC loop opens");
        chk(oc_pin[0], 1'b0, "alarm on OC11");
        chk(irq, 1'b1, "irq raised");
        wb(1'b0, 8'h18, 32'h0);
        chk(rd[0], 1'b1, "alarm rise sticky");
        chk(irq, 1'b0, "irq after clear");
        trip_i <= 1'b0;
        cyc(AD + 3);
        chk(alarm, 1'b0, "alarm clears");
        chk(irq, 1'b0, "fall bit masked");
        chk(loop_closed, 1'b1, "NC loop recloses");
        wb(1'b1, 8'h04, 32'h0);
        chk(relay, 1'b0, "NO relay idle");
        trip_i <= 1'b1;
        cyc(AD + 3);
        chk(relay, 1'b1, "NO relay in trip");
        summarize();
    end
endmodule : tb_fault_and_input_loss_outputs
